//--- smac_regs.svh
`ifndef SMAC_REGS_SVH
`define SMAC_REGS_SVH

// Device byte map
`define SMAC_CFG_BASE 10'h200
`define SMAC_BUF_BASE 10'h300
`define SMAC_META_LO 10'h310
`define SMAC_META_HI 10'h311
`define SMAC_PEND 10'h312

// Config offsets
`define SMAC_FUSE_OFS 8'h00
`define SMAC_SYS_LO 8'h10
`define SMAC_SYS_HI 8'h1F
`define SMAC_ZCFG_LO 8'h20
`define SMAC_ZCFG_HI 8'h2F
`define SMAC_KEY_OFS 8'h90
`define SMAC_PW_OFS 8'hD0

// Zone access byte fields, then the system byte anti-tearing bit
`define SMAC_ZC_PWR 0
`define SMAC_ZC_PWW 1
`define SMAC_ZC_AUTH 2
`define SMAC_ZC_ENC 3
`define SMAC_ZC_SET 4
`define SMAC_SYS_AT 0

`define SMAC_TRANSPORT_PW 24'h301DD2
`define SMAC_ATC_LIMIT 3'h4
`define SMAC_AT_MAX_LEN 4'h7
`define SMAC_FUSE_NUM 2'h3

// Controller word indices
`define SMAC_R_CMD 6'h00
`define SMAC_R_WD0 6'h01
`define SMAC_R_WD3 6'h04
`define SMAC_R_CHK 6'h05
`define SMAC_R_STAT 6'h06
`define SMAC_R_RDLO 6'h07
`define SMAC_R_RDHI 6'h08

// Command word fields
`define SMAC_C_OP 0
`define SMAC_C_ZONE 4
`define SMAC_C_IDX 8
`define SMAC_C_CFG 11
`define SMAC_C_CHKEN 12
`define SMAC_C_LEN 16
`define SMAC_C_ADDR 24

`endif

//--- smac_pkg.sv
package smac_pkg;
    typedef enum logic [3:0] {
        OP_NOP, OP_READ, OP_WRITE, OP_CHECK_PW, OP_AUTH, OP_ENC, OP_DESELECT, OP_IDLE, OP_FUSE
    } smac_op_t;

    typedef enum logic [1:0] {MODE_STD, MODE_AUTH, MODE_ENC} smac_mode_t;

    typedef enum logic [2:0] {DS_POR, DS_HALT, DS_READY, DS_BUF, DS_META, DS_COPY, DS_DONE} smac_dst_t;

    typedef struct packed {
        logic [2:0] count;
    } smac_atc_st_t;

    typedef struct packed {
        smac_dst_t state;
        smac_mode_t mode;
        logic pw_valid;
        logic pw_write;
        logic [1:0] pw_set;
        logic cfg_unlock;
        logic auth_ok;
        logic [1:0] auth_set;
        logic [63:0] sess;
        logic [127:0] wdata;
        logic [9:0] tgt;
        logic [3:0] len;
        logic [3:0] idx;
        logic src_buf;
        logic recov;
        logic active;
        logic [2:0] fuses;
        logic rsp_valid;
        logic rsp_ok;
        logic rsp_enc;
        logic [63:0] rsp_data;
    } smac_dev_st_t;

    typedef struct packed {
        logic busy;
        logic ok;
        logic enc;
        logic [1:0] mode;
        logic [63:0] rdata;
        logic [31:0] cmd;
        logic [127:0] wdata;
        logic [15:0] chk;
        logic cmd_valid;
        logic wr_pend;
        logic [5:0] wr_idx;
        logic [31:0] hrdata;
        logic hready;
    } smac_rdr_st_t;
endpackage : smac_pkg

//--- smac_link_if.sv
`timescale 1ns/1ps
interface smac_link_if;
    logic cmd_valid;
    smac_pkg::smac_op_t cmd_op;
    logic [1:0] cmd_zone;
    logic [2:0] cmd_idx;
    logic cmd_cfg;
    logic [7:0] cmd_addr;
    logic [3:0] cmd_len;
    logic [127:0] cmd_data;
    logic cmd_chk_en;
    logic [15:0] cmd_chk;
    logic rsp_valid;
    logic rsp_ok;
    logic rsp_enc;
    logic [63:0] rsp_data;
    smac_pkg::smac_mode_t rsp_mode;

    modport dev (
        input cmd_valid, cmd_op, cmd_zone, cmd_idx, cmd_cfg, cmd_addr, cmd_len, cmd_data,
        input cmd_chk_en, cmd_chk,
        output rsp_valid, rsp_ok, rsp_enc, rsp_data, rsp_mode
    );
    modport rdr (
        output cmd_valid, cmd_op, cmd_zone, cmd_idx, cmd_cfg, cmd_addr, cmd_len, cmd_data,
        output cmd_chk_en, cmd_chk,
        input rsp_valid, rsp_ok, rsp_enc, rsp_data, rsp_mode
    );
endinterface : smac_link_if

//--- smac_atc.sv
`timescale 1ns/1ps
`include "smac_regs.svh"
module smac_atc (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic inc_in,
    input wire logic clr_in,
    output logic locked_out
);
    smac_pkg::smac_atc_st_t r, n;

    always_comb begin
        n = r;
        if (clr_in) begin
            n.count = 3'h0;
        end else if (inc_in && r.count != `SMAC_ATC_LIMIT) begin
            n.count = r.count + 3'h1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign locked_out = (r.count == `SMAC_ATC_LIMIT);
endmodule : smac_atc

//--- smac_rdr.sv
`timescale 1ns/1ps
`include "smac_regs.svh"
module smac_rdr (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    smac_link_if.rdr LINK
);
    smac_pkg::smac_rdr_st_t r, n;
    logic addr_ph;

    // Whole words only
    assign addr_ph = HSEL_IN && HTRANS_IN[1] && HREADY_IN && (HSIZE_IN == 3'h2);

    always_comb begin
        n = r;
        n.cmd_valid = 1'b0;
        n.hready = 1'b1;
        if (r.wr_pend) begin
            case (r.wr_idx)
                `SMAC_R_CMD: begin
                    // Dropped while busy
                    if (!r.busy) begin
                        n.cmd = HWDATA_IN;
                        n.cmd_valid = 1'b1;
                        n.busy = 1'b1;
                    end
                end
                `SMAC_R_CHK: n.chk = HWDATA_IN[15:0]; // R18
                default: begin
                    if (r.wr_idx >= `SMAC_R_WD0 && r.wr_idx <= `SMAC_R_WD3) begin
                        n.wdata[(r.wr_idx - `SMAC_R_WD0) * 32 +: 32] = HWDATA_IN;
                    end
                end
            endcase
        end
        n.wr_pend = addr_ph && HWRITE_IN;
        if (addr_ph) begin
            n.wr_idx = HADDR_IN[7:2];
        end
        if (addr_ph && !HWRITE_IN) begin
            case (HADDR_IN[7:2])
                `SMAC_R_CMD: n.hrdata = r.cmd;
                `SMAC_R_CHK: n.hrdata = {16'h0000, r.chk};
                `SMAC_R_STAT: n.hrdata = {26'h0000000, r.mode, 1'b0, r.enc, r.ok, r.busy};
                `SMAC_R_RDLO: n.hrdata = r.rdata[31:0];
                `SMAC_R_RDHI: n.hrdata = r.rdata[63:32];
                default: begin
                    if (HADDR_IN[7:2] >= `SMAC_R_WD0 && HADDR_IN[7:2] <= `SMAC_R_WD3) begin
                        n.hrdata = r.wdata[(HADDR_IN[7:2] - `SMAC_R_WD0) * 32 +: 32];
                    end else begin
                        n.hrdata = 32'h00000000;
                    end
                end
            endcase
        end
        if (LINK.rsp_valid) begin
            n.busy = 1'b0;
            n.ok = LINK.rsp_ok;
            n.enc = LINK.rsp_enc;
            n.mode = LINK.rsp_mode;
            n.rdata = LINK.rsp_data;
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign HRDATA_OUT = r.hrdata;
    assign HREADYOUT_OUT = r.hready;
    assign HRESP_OUT = 1'b0;
    assign LINK.cmd_valid = r.cmd_valid;
    assign LINK.cmd_op = smac_pkg::smac_op_t'(r.cmd[`SMAC_C_OP +: 4]); // R2
    assign LINK.cmd_zone = r.cmd[`SMAC_C_ZONE +: 2]; // R7
    assign LINK.cmd_idx = r.cmd[`SMAC_C_IDX +: 3];
    assign LINK.cmd_cfg = r.cmd[`SMAC_C_CFG]; // R20
    assign LINK.cmd_chk_en = r.cmd[`SMAC_C_CHKEN];
    assign LINK.cmd_len = r.cmd[`SMAC_C_LEN +: 4];
    assign LINK.cmd_addr = r.cmd[`SMAC_C_ADDR +: 8];
    assign LINK.cmd_data = r.wdata;
    assign LINK.cmd_chk = r.chk;
endmodule : smac_rdr

//--- smac_dev.sv
// What this block does
// R1: 2048-bit configuration area, access fixed in logic
// R2: Three fuses, blown strictly in order, lock regions
// R3: Start in standard mode after power-up, anticollision
// R4: Authenticated then encrypted only on success
// R5: Mode decides which traffic is encrypted
// R6: One attempts counter per password and key; the transport password check has no counter
// R7: Zones demand their own passwords or keys
// R8: Anti-tearing limits writes to 8 bytes
// R9: Anti-tearing writes buffer first, then copy
// R10: Interrupted copy restored from buffer at power-up
// R11: Password holds until power, replaced, deselect, idle
// R12: One active password; write password grants read
// R13: Authentication holds until restart, deselect, idle
// R14: Failed authentication drops earlier authentication
// R15: Encryption-keyed zones need encrypted mode
// R16: Encryption holds; failed activation stops encrypting
// R17: Standard checksum or cryptographic MAC on writes
// R18: MAC mismatch aborts and leaves cryptographic mode
// R19: Shipped with security disabled, personalized by writes
// R20: Configuration access needs the transport password
// R21: Commands accepted only after anticollision completes
// R22: Exhausted counter refuses further checks
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "smac_regs.svh"
module smac_dev (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic ANTICOL_DONE_IN,
    output logic [1:0] MODE_OUT,
    output logic ACTIVE_OUT,
    output logic [2:0] FUSES_OUT,
    smac_link_if.dev LINK
);
    smac_pkg::smac_dev_st_t r, n;
    logic [7:0] mem [0:1023];
    logic mem_we;
    logic [9:0] mem_wa;
    logic [7:0] mem_wd;
    logic [11:0] cnt_inc, cnt_clr, locked;

    function automatic logic [63:0] rd8(input logic [9:0] a);
        logic [63:0] v;
        v = 64'h0;
        for (int i = 0; i < 8; i++) begin
            v[i * 8 +: 8] = mem[a + 10'(i)];
        end
        return v;
    endfunction : rd8

    function automatic logic [15:0] sum16(input logic [127:0] d, input logic [3:0] len);
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (4'(i) <= len) begin
                s = s + {8'h00, d[i * 8 +: 8]};
            end
        end
        return s;
    endfunction : sum16

    function automatic logic cfg_lock(input logic [7:0] a, input logic [2:0] f);
        return (a == `SMAC_FUSE_OFS) || (f[0] && a >= `SMAC_KEY_OFS) ||
            (f[1] && a >= `SMAC_ZCFG_LO && a <= `SMAC_ZCFG_HI) ||
            (f[2] && a >= `SMAC_SYS_LO && a <= `SMAC_SYS_HI); // R2
    endfunction : cfg_lock

    function automatic logic [63:0] key_of(input logic [1:0] set);
        return rd8(`SMAC_CFG_BASE + {2'h0, `SMAC_KEY_OFS + {3'h0, set, 3'h0}});
    endfunction : key_of

    // Counters: write pw, read pw, key
    genvar g;
    generate
        for (g = 0; g < 12; g++) begin : g_atc
            smac_atc u_atc (
                .clk_in(CLK_SYS_IN),
                .rst_in(RST_IN),
                .inc_in(cnt_inc[g]),
                .clr_in(cnt_clr[g]),
                .locked_out(locked[g])
            ); // R6
        end
    endgenerate

    logic [7:0] zc, pw_addr;
    logic [1:0] zset;
    logic gate_ae, rd_ok, wr_ok, at_en, in_range, w_access, mac_mode, chk_bad, pw_ok;
    logic [9:0] maddr;
    logic [127:0] wdec;
    logic [23:0] pw_in;
    logic [3:0] pw_cnt;
    logic [2:0] fuse_low;

    assign zc = mem[`SMAC_CFG_BASE + {2'h0, `SMAC_ZCFG_LO} + {8'h00, LINK.cmd_zone}];
    assign zset = zc[`SMAC_ZC_SET +: 2];
    assign gate_ae = (!zc[`SMAC_ZC_AUTH] || (r.auth_ok && r.auth_set == zset)) &&
        (!zc[`SMAC_ZC_ENC] || r.mode == smac_pkg::MODE_ENC); // R15
    assign rd_ok = gate_ae && (!zc[`SMAC_ZC_PWR] || (r.pw_valid && r.pw_set == zset)); // R12
    assign wr_ok = gate_ae &&
        (!zc[`SMAC_ZC_PWW] || (r.pw_valid && r.pw_write && r.pw_set == zset)); // R7
    assign at_en = mem[`SMAC_CFG_BASE + {2'h0, `SMAC_SYS_LO}][`SMAC_SYS_AT];
    assign maddr = LINK.cmd_cfg ? `SMAC_CFG_BASE + {2'h0, LINK.cmd_addr} :
        {1'b0, LINK.cmd_zone, LINK.cmd_addr[6:0]};
    assign in_range = LINK.cmd_cfg ? ({1'b0, LINK.cmd_addr} + {5'h00, LINK.cmd_len} <= 9'h0FF) :
        ({1'b0, LINK.cmd_addr[6:0]} + {4'h0, LINK.cmd_len} <= 8'h7F);
    assign w_access = LINK.cmd_cfg ? (r.cfg_unlock && !cfg_lock(LINK.cmd_addr, r.fuses) &&
        !cfg_lock(LINK.cmd_addr + {4'h0, LINK.cmd_len}, r.fuses)) : wr_ok; // R1
    // Stand-in cipher: session key stream
    assign wdec = (r.mode == smac_pkg::MODE_ENC && !LINK.cmd_cfg) ?
        LINK.cmd_data ^ {r.sess, r.sess} : LINK.cmd_data; // R5
    assign mac_mode = (r.mode != smac_pkg::MODE_STD);
    assign chk_bad = (mac_mode || LINK.cmd_chk_en) && (LINK.cmd_chk !=
        (sum16(wdec, LINK.cmd_len) ^ (mac_mode ? r.sess[15:0] : 16'h0000))); // R17
    assign pw_in = mac_mode ? LINK.cmd_data[23:0] ^ r.sess[23:0] : LINK.cmd_data[23:0]; // R5
    assign pw_addr = `SMAC_PW_OFS + {3'h0, LINK.cmd_idx[1:0], 3'h0} +
        {5'h00, !LINK.cmd_idx[2], 2'h0};
    assign pw_ok = (pw_in == 24'(rd8(`SMAC_CFG_BASE + {2'h0, pw_addr})));
    assign pw_cnt = {1'b0, !LINK.cmd_idx[2], LINK.cmd_idx[1:0]};
    assign fuse_low = 3'((4'h1 << LINK.cmd_idx[1:0]) - 4'h1);

    always_comb begin
        n = r;
        n.rsp_valid = 1'b0;
        n.fuses = mem[`SMAC_CFG_BASE + {2'h0, `SMAC_FUSE_OFS}][2:0];
        mem_we = 1'b0;
        mem_wa = 10'h000;
        mem_wd = 8'h00;
        cnt_inc = 12'h000;
        cnt_clr = 12'h000;
        case (r.state)
            smac_pkg::DS_POR: begin
                if (mem[`SMAC_PEND] != 8'h00) begin
                    n.tgt = {mem[`SMAC_META_HI][1:0], mem[`SMAC_META_LO]}; // R10
                    n.len = mem[`SMAC_META_HI][7:4];
                    n.src_buf = 1'b1;
                    n.recov = 1'b1;
                    n.idx = 4'h0;
                    n.state = smac_pkg::DS_COPY;
                end else begin
                    n.state = smac_pkg::DS_HALT;
                end
            end
            smac_pkg::DS_HALT: begin
                n.mode = smac_pkg::MODE_STD; // R3
                if (ANTICOL_DONE_IN) begin
                    n.active = 1'b1;
                    n.state = smac_pkg::DS_READY; // R21
                end
            end
            smac_pkg::DS_READY: begin
                if (LINK.cmd_valid) begin
                    n.rsp_valid = 1'b1;
                    n.rsp_ok = 1'b0;
                    n.rsp_enc = 1'b0;
                    n.rsp_data = 64'h0;
                    case (LINK.cmd_op)
                        smac_pkg::OP_READ: begin
                            n.rsp_ok = LINK.cmd_cfg ? r.cfg_unlock : rd_ok; // R20
                            n.rsp_enc = !LINK.cmd_cfg && r.mode == smac_pkg::MODE_ENC; // R5
                            if (n.rsp_ok) begin
                                n.rsp_data = rd8(maddr) ^ (n.rsp_enc ? r.sess : 64'h0);
                            end
                        end
                        smac_pkg::OP_WRITE: begin
                            if (chk_bad) begin
                                n.mode = smac_pkg::MODE_STD; // R18
                                n.auth_ok = 1'b0;
                            end else if (w_access && in_range &&
                                !(at_en && LINK.cmd_len > `SMAC_AT_MAX_LEN)) begin // R8
                                n.rsp_valid = 1'b0;
                                n.tgt = maddr;
                                n.len = LINK.cmd_len;
                                n.wdata = wdec;
                                n.idx = 4'h0;
                                n.recov = 1'b0;
                                n.src_buf = at_en;
                                n.state = at_en ? smac_pkg::DS_BUF : smac_pkg::DS_COPY; // R9
                            end
                        end
                        smac_pkg::OP_CHECK_PW: begin
                            n.pw_valid = 1'b0; // R12
                            n.cfg_unlock = 1'b0;
                            if (LINK.cmd_cfg) begin
                                n.cfg_unlock = (pw_in == `SMAC_TRANSPORT_PW); // R20
                                n.rsp_ok = n.cfg_unlock;
                            end else if (!locked[pw_cnt]) begin // R22
                                n.rsp_ok = pw_ok;
                                n.pw_valid = pw_ok; // R11
                                n.pw_write = LINK.cmd_idx[2];
                                n.pw_set = LINK.cmd_idx[1:0];
                                cnt_clr[pw_cnt] = pw_ok;
                                cnt_inc[pw_cnt] = !pw_ok; // R6
                            end
                        end
                        smac_pkg::OP_AUTH: begin
                            n.auth_ok = 1'b0; // R14
                            n.mode = smac_pkg::MODE_STD;
                            if (!locked[4'h8 + {2'h0, LINK.cmd_idx[1:0]}]) begin // R22
                                n.rsp_ok = (LINK.cmd_data[63:0] == key_of(LINK.cmd_idx[1:0]));
                                cnt_clr[4'h8 + {2'h0, LINK.cmd_idx[1:0]}] = n.rsp_ok;
                                cnt_inc[4'h8 + {2'h0, LINK.cmd_idx[1:0]}] = !n.rsp_ok;
                                if (n.rsp_ok) begin
                                    n.auth_ok = 1'b1; // R13
                                    n.auth_set = LINK.cmd_idx[1:0];
                                    n.sess = key_of(LINK.cmd_idx[1:0]);
                                    n.mode = smac_pkg::MODE_AUTH; // R4
                                end
                            end
                        end
                        smac_pkg::OP_ENC: begin
                            if (r.auth_ok) begin
                                n.rsp_ok = (LINK.cmd_data[63:0] == ~key_of(r.auth_set));
                                n.mode = n.rsp_ok ? smac_pkg::MODE_ENC :
                                    smac_pkg::MODE_AUTH; // R16
                            end
                        end
                        smac_pkg::OP_DESELECT, smac_pkg::OP_IDLE: begin
                            n.rsp_ok = 1'b1;
                            n.pw_valid = 1'b0; // R11
                            n.cfg_unlock = 1'b0;
                            n.auth_ok = 1'b0; // R13
                            n.mode = smac_pkg::MODE_STD; // R16
                            n.active = 1'b0;
                            n.state = smac_pkg::DS_HALT;
                        end
                        smac_pkg::OP_FUSE: begin
                            if (r.cfg_unlock && LINK.cmd_idx[1:0] < `SMAC_FUSE_NUM &&
                                (r.fuses & fuse_low) == fuse_low) begin // R2
                                n.rsp_ok = 1'b1;
                                mem_we = 1'b1;
                                mem_wa = `SMAC_CFG_BASE + {2'h0, `SMAC_FUSE_OFS};
                                mem_wd = {5'h00, r.fuses | 3'(4'h1 << LINK.cmd_idx[1:0])};
                            end
                        end
                        default: n.rsp_ok = 1'b0;
                    endcase
                end
            end
            smac_pkg::DS_BUF: begin
                mem_we = 1'b1; // R9
                mem_wa = `SMAC_BUF_BASE + {6'h00, r.idx};
                mem_wd = r.wdata[r.idx * 8 +: 8];
                n.idx = r.idx + 4'h1;
                if (r.idx == r.len) begin
                    n.idx = 4'h0;
                    n.state = smac_pkg::DS_META;
                end
            end
            smac_pkg::DS_META: begin
                mem_we = 1'b1;
                n.idx = r.idx + 4'h1;
                case (r.idx)
                    4'h0: begin
                        mem_wa = `SMAC_META_LO;
                        mem_wd = r.tgt[7:0];
                    end
                    4'h1: begin
                        mem_wa = `SMAC_META_HI;
                        mem_wd = {r.len, 2'h0, r.tgt[9:8]};
                    end
                    default: begin
                        mem_wa = `SMAC_PEND; // R10
                        mem_wd = 8'h01;
                        n.idx = 4'h0;
                        n.state = smac_pkg::DS_COPY;
                    end
                endcase
            end
            smac_pkg::DS_COPY: begin
                mem_we = 1'b1;
                mem_wa = r.tgt + {6'h00, r.idx};
                mem_wd = r.src_buf ? mem[`SMAC_BUF_BASE + {6'h00, r.idx}] :
                    r.wdata[r.idx * 8 +: 8];
                n.idx = r.idx + 4'h1;
                if (r.idx == r.len) begin
                    n.state = smac_pkg::DS_DONE;
                end
            end
            smac_pkg::DS_DONE: begin
                mem_we = 1'b1;
                mem_wa = `SMAC_PEND;
                mem_wd = 8'h00;
                n.rsp_valid = !r.recov;
                n.rsp_ok = 1'b1;
                n.rsp_enc = 1'b0;
                n.rsp_data = 64'h0;
                n.state = r.recov ? smac_pkg::DS_HALT : smac_pkg::DS_READY;
            end
            default: n.state = smac_pkg::DS_POR;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Array survives reset
    always @(posedge CLK_SYS_IN) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Delivery state: all security off
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 8'h00; // R19
        end
    end

    assign MODE_OUT = r.mode;
    assign ACTIVE_OUT = r.active;
    assign FUSES_OUT = r.fuses;
    assign LINK.rsp_valid = r.rsp_valid;
    assign LINK.rsp_ok = r.rsp_ok;
    assign LINK.rsp_enc = r.rsp_enc;
    assign LINK.rsp_data = r.rsp_data;
    assign LINK.rsp_mode = r.mode;
endmodule : smac_dev

//--- smac_link_sva.sv
`timescale 1ns/1ps
module smac_link_sva (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire smac_pkg::smac_op_t cmd_op,
    input wire logic [2:0] cmd_idx,
    input wire logic cmd_cfg,
    input wire logic rsp_valid,
    input wire logic rsp_ok,
    input wire logic rsp_enc,
    input wire smac_pkg::smac_mode_t rsp_mode
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);
    a_auth_entry: assert property ($changed(rsp_mode) && rsp_mode == smac_pkg::MODE_AUTH
        |-> cmd_op inside {smac_pkg::OP_AUTH, smac_pkg::OP_ENC}) else $error("bad auth entry");
    a_enc_entry: assert property ($changed(rsp_mode) && rsp_mode == smac_pkg::MODE_ENC
        |-> cmd_op == smac_pkg::OP_ENC && $past(rsp_mode) == smac_pkg::MODE_AUTH)
        else $error("bad encrypted entry");
    a_auth_fail_drop: assert property (rsp_valid && cmd_op == smac_pkg::OP_AUTH && !rsp_ok
        |=> rsp_mode == smac_pkg::MODE_STD) else $error("failed auth kept mode");
    a_enc_fail_drop: assert property (rsp_valid && cmd_op == smac_pkg::OP_ENC && !rsp_ok
        |=> rsp_mode != smac_pkg::MODE_ENC) else $error("failed activation kept mode");
    a_deselect_clear: assert property (rsp_valid && cmd_op inside
        {smac_pkg::OP_DESELECT, smac_pkg::OP_IDLE} |-> rsp_ok ##1 rsp_mode == smac_pkg::MODE_STD)
        else $error("grants kept after deselect");
    a_enc_read: assert property (rsp_valid && rsp_ok && cmd_op == smac_pkg::OP_READ && !cmd_cfg
        && rsp_mode == smac_pkg::MODE_ENC |-> rsp_enc) else $error("clear read in enc mode");
    a_std_clear: assert property (rsp_valid && rsp_ok && cmd_op == smac_pkg::OP_READ
        && rsp_mode == smac_pkg::MODE_STD |-> !rsp_enc) else $error("enc read in std mode");
    a_fuse_range: assert property (rsp_valid && cmd_op == smac_pkg::OP_FUSE
        && cmd_idx[1:0] == 2'h3 |-> !rsp_ok) else $error("fuse 3 accepted");
    c_enc: cover property (rsp_valid && rsp_mode == smac_pkg::MODE_ENC);
    c_desel: cover property (rsp_valid && cmd_op == smac_pkg::OP_DESELECT);
    c_refused: cover property (rsp_valid && !rsp_ok);
endmodule : smac_link_sva

//--- tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic ok; logic dc; logic [63:0] d;} smac_exp_t;
    logic clk = 1'h0, rst = 1'h1, anti = 1'h0, hw = 1'h0, hrdy, act;
    logic [1:0] ht = 2'h0, mode;
    logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, r, s;
    logic [63:0] d;
    logic [2:0] fu;
    int n_fail = 0, samples_checked = 0, i;
    smac_exp_t q[$], e;
    smac_link_if link ();
    smac_dev smac_dev_inst (.CLK_SYS_IN(clk), .RST_IN(rst), .ANTICOL_DONE_IN(anti),
        .MODE_OUT(mode), .ACTIVE_OUT(act), .FUSES_OUT(fu), .LINK(link.dev));
    smac_rdr smac_rdr_inst (.CLK_SYS_IN(clk), .RST_IN(rst), .HSEL_IN(1'h1), .HADDR_IN(ha),
        .HTRANS_IN(ht), .HWRITE_IN(hw), .HSIZE_IN(3'h2), .HWDATA_IN(hwd), .HREADY_IN(hrdy),
        .HRDATA_OUT(hrd), .HREADYOUT_OUT(hrdy), .HRESP_OUT(), .LINK(link.rdr));
    smac_link_sva smac_link_sva_inst (.CLK_SYS_IN(clk), .RST_IN(rst), .cmd_op(link.cmd_op),
        .cmd_idx(link.cmd_idx), .cmd_cfg(link.cmd_cfg), .rsp_valid(link.rsp_valid),
        .rsp_ok(link.rsp_ok), .rsp_enc(link.rsp_enc), .rsp_mode(link.rsp_mode));
    always #5 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], 1'h0} ^ (v[31] ? 32'h000000C5 : 32'h0);
    endfunction : lfsr
    task automatic chk(input logic [63:0] seen, input logic [63:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, seen, want);
        end
    endtask : chk
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    task automatic wt;
        int n;
        @(posedge clk);
        for (n = 0; n < 20 && hrdy !== 1'h1; n++) @(posedge clk);
        if (n == 20) begin
            chk(64'h1, 64'h0);
            test_done;
        end
    endtask : wt
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        ha <= {24'h0, a};
        hw <= w;
        ht <= 2'h2;
        wt;
        ht <= 2'h0;
        hwd <= wd;
        wt;
        r = hrd;
    endtask : ahb
    // One command, then poll busy
    task automatic cmd(input logic [3:0] op, input logic c, input logic [2:0] x,
        input logic [63:0] wd, input logic ok, input logic [63:0] ed);
        int n;
        q.push_back({ok, op == smac_pkg::OP_READ && ok, ed});
        ahb(1'h1, 8'h04, wd[31:0]);
        ahb(1'h1, 8'h08, wd[63:32]);
        ahb(1'h1, 8'h00, {c ? 8'h90 : 8'h08, 8'h07, 3'h0, 1'h0, c, x, 4'h0, op});
        repeat (4) @(posedge clk);
        n = 0;
        do begin
            ahb(1'h0, 8'h18, 32'h0);
            n++;
        end while (r[0] !== 1'h0 && n < 40);
        if (n == 40) begin
            chk(64'h1, 64'h0);
            test_done;
        end
    endtask : cmd
    always @(posedge clk) begin
        if (link.rsp_valid === 1'h1) begin
            e = (q.size() > 0) ? q.pop_front() : smac_exp_t'('1);
            chk(link.rsp_ok, e.ok);
            if (e.dc) chk(link.rsp_data, e.d);
        end
    end
    initial begin
        s = lfsr(32'h02476535);
        d = {lfsr(s), s};
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        repeat (6) @(posedge clk);
        chk(act, 1'h0);
        chk(mode, 2'h0);
        anti <= 1'h1;
        for (i = 0; i < 20 && act !== 1'h1; i++) @(posedge clk);
        chk(act, 1'h1);
        cmd(smac_pkg::OP_WRITE, 1'h0, 3'h0, d, 1'h1, 64'h0);
        cmd(smac_pkg::OP_READ, 1'h0, 3'h0, 64'h0, 1'h1, d);
        cmd(smac_pkg::OP_READ, 1'h1, 3'h0, 64'h0, 1'h0, 64'h0);
        cmd(smac_pkg::OP_CHECK_PW, 1'h1, 3'h0, 64'h301DD2, 1'h1, 64'h0);
        cmd(smac_pkg::OP_READ, 1'h1, 3'h0, 64'h0, 1'h1, 64'h0);
        cmd(smac_pkg::OP_FUSE, 1'h0, 3'h1, 64'h0, 1'h0, 64'h0);
        cmd(smac_pkg::OP_FUSE, 1'h0, 3'h3, 64'h0, 1'h0, 64'h0);
        chk(fu, 3'h0);
        cmd(smac_pkg::OP_CHECK_PW, 1'h1, 3'h0, 64'h301DD3, 1'h0, 64'h0);
        cmd(smac_pkg::OP_READ, 1'h1, 3'h0, 64'h0, 1'h0, 64'h0);
        cmd(smac_pkg::OP_AUTH, 1'h0, 3'h0, 64'h0, 1'h1, 64'h0);
        cmd(smac_pkg::OP_ENC, 1'h0, 3'h0, ~64'h0, 1'h1, 64'h0);
        chk(mode, 2'h2);
        cmd(smac_pkg::OP_READ, 1'h0, 3'h0, 64'h0, 1'h1, d);
        cmd(smac_pkg::OP_ENC, 1'h0, 3'h0, 64'h0, 1'h0, 64'h0);
        chk(mode, 2'h1);
        cmd(smac_pkg::OP_AUTH, 1'h0, 3'h0, 64'h5, 1'h0, 64'h0);
        cmd(smac_pkg::OP_ENC, 1'h0, 3'h0, ~64'h0, 1'h0, 64'h0);
        chk(mode, 2'h0);
        for (i = 0; i < 5; i++) cmd(smac_pkg::OP_AUTH, 1'h0, 3'h1, {63'h0, i < 4}, 1'h0, 64'h0);
        cmd(smac_pkg::OP_AUTH, 1'h0, 3'h0, 64'h0, 1'h1, 64'h0);
        cmd(smac_pkg::OP_DESELECT, 1'h0, 3'h0, 64'h0, 1'h1, 64'h0);
        chk(mode, 2'h0);
        cmd(smac_pkg::OP_IDLE, 1'h0, 3'h0, 64'h0, 1'h1, 64'h0);
        chk(q.size(), 64'h0);
        test_done;
    end
endmodule : tb
